/* File: testbench/mdu_core_model.sv */
// mdu_core_model: core side raising interrupts and counting refetches.
// assumes the bench raises take_req for one cycle after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module mdu_core_model (
    // clock and bench requests
    input wire logic clk,
    input wire logic take_req,
    input wire logic [15:0] take_pc,
    // unit side
    output logic irq_take,
    output logic [15:0] irq_pc,
    input wire logic [15:0] return_addr,
    input wire logic refetch,
    // what the core saw
    output logic [15:0] pushed_addr,
    output int n_refetch
);
    logic take_d;
    // quiet start
    initial begin
        irq_take = 1'b0;
        irq_pc = 16'h0000;
        take_d = 1'b0;
        pushed_addr = 16'h0000;
        n_refetch = 0;
    end
    // pulse, address only meaningful with it
    always @(posedge clk) begin
        irq_take <= take_req;
        irq_pc <= take_req ? take_pc : ~irq_pc;
    end
    always @(posedge clk) begin
        take_d <= irq_take;
        if (take_d)
            pushed_addr <= return_addr;
    end
    always @(posedge clk) begin
        if (refetch)
            n_refetch <= n_refetch + 1;
    end
endmodule
`default_nettype wire

/* File: testbench/mdu_unit_properties.sv */
// mdu_unit_properties: port-level checks of the multiply/divide unit.
// assumes it is bound to mdu_unit and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module mdu_checker #(
    parameter int ADDR_WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // bus side
    input wire logic hsel,
    input wire logic [ADDR_WIDTH-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // core side
    input wire logic irq_take,
    input wire logic [15:0] irq_pc,
    input wire logic [15:0] return_addr,
    input wire logic refetch,
    input wire logic irq
);
    logic ph_rd;
    logic ph_wr;
    logic [ADDR_WIDTH-1:0] ph_addr;
    logic [15:0] op_addr;
    logic return_from_interrupt_set;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // address phase remembered for its data phase
    always_ff @(posedge clk) begin
        if (srst) begin
            ph_rd <= 1'b0;
            ph_wr <= 1'b0;
            ph_addr <= '0;
            op_addr <= '0;
        end else begin
            ph_rd <= hsel && htrans == mdu_pkg::HTRANS_NONSEQ && !hwrite;
            ph_wr <= hsel && htrans == mdu_pkg::HTRANS_NONSEQ && hwrite;
            ph_addr <= haddr;
            if (ph_wr && ph_addr == mdu_pkg::ADDR_CMD)
                op_addr <= hwdata[31:16];
        end
    end
    // return write, whatever flag value it restores
    assign return_from_interrupt_set = ph_wr && ph_addr == mdu_pkg::ADDR_RETURN_FROM_INTERRUPT;
    property p_ready;
        hreadyout && !hresp;
    endproperty
    a_ready: assert property (p_ready) else $error("bus stall or error");
    property p_half;
        ph_rd && ph_addr <= mdu_pkg::ADDR_HIGH |-> hrdata[31:16] == 16'h0000;
    endproperty
    a_half: assert property (p_half) else $error("half upper bits");
    property p_ctrl;
        ph_rd && ph_addr == mdu_pkg::ADDR_CTRL |-> hrdata[31:5] == '0;
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control shape");
    property p_unmapped;
        ph_rd && ph_addr > mdu_pkg::ADDR_RETURN_FROM_INTERRUPT |-> hrdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_pulse;
        refetch |=> !refetch;
    endproperty
    a_pulse: assert property (p_pulse) else $error("refetch too long");
    property p_cause;
        $rose(refetch) |-> $past(return_from_interrupt_set) || $past(return_from_interrupt_set, 2);
    endproperty
    a_cause: assert property (p_cause) else $error("refetch uncaused");
    property p_take;
        irq_take |=> return_addr == $past(irq_pc) || return_addr == op_addr;
    endproperty
    a_take: assert property (p_take) else $error("wrong push address");
    property p_hold;
        !irq_take |=> $stable(return_addr);
    endproperty
    a_hold: assert property (p_hold) else $error("push address moved");
    property p_fall;
        $fell(irq) |-> $past(ph_wr) || $past(ph_wr, 2);
    endproperty
    a_fall: assert property (p_fall) else $error("irq dropped alone");
    c_refetch: cover property (refetch);
    c_irq: cover property ($rose(irq));
    c_take: cover property (irq_take);
endmodule
bind mdu_unit mdu_checker #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (
    .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq_take(irq_take),
    .irq_pc(irq_pc), .return_addr(return_addr), .refetch(refetch),
    .irq(irq)
);
`default_nettype wire

/* File: testbench/tb_mul_div_unit.sv */
// tb_mul_div_unit: self-checking bench for the multiply/divide unit.
// assumes the unit, its checker and the core model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_mul_div_unit;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic irq_take;
    logic [15:0] irq_pc;
    logic [15:0] return_addr;
    logic refetch;
    logic irq;
    logic take_req = 1'b0;
    logic [15:0] take_pc = 16'h1111;
    logic [15:0] pushed_addr;
    logic [31:0] rd;
    int n_refetch;
    int n_errors = 0;
    int checked = 0;
    // 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end
    mdu_unit dut (
        .clk(clk), .srst(srst), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(mdu_pkg::HSIZE_WORD),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(), .irq_take(irq_take),
        .irq_pc(irq_pc), .return_addr(return_addr), .refetch(refetch),
        .irq(irq)
    );
    mdu_core_model core (
        .clk(clk), .take_req(take_req), .take_pc(take_pc),
        .irq_take(irq_take), .irq_pc(irq_pc), .return_addr(return_addr),
        .refetch(refetch), .pushed_addr(pushed_addr), .n_refetch(n_refetch)
    );
    task automatic complete_run;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one bus phase, ended by ready at a rising edge
    task automatic phase;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) begin
            n_errors++;
            complete_run();
        end
    endtask
    // single word transfer, read data into rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= mdu_pkg::HTRANS_NONSEQ;
        phase();
        htrans <= 2'h0;
        hwdata <= d;
        phase();
        rd = hrdata;
    endtask
    // poll until the operation has finished
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            bus(1'b0, mdu_pkg::ADDR_STAT, 32'h0);
            n++;
        end while (rd[2] !== 1'b0 && n < 40);
        cmp("busy", 32'h0, {31'h0, rd[2]});
        if (rd[2] !== 1'b0) begin
            complete_run();
        end
    endtask
    // reset values, save and restore of the halves
    task automatic s_regs;
        bus(1'b0, mdu_pkg::ADDR_STAT, 32'h0);
        cmp("stat", 32'h0, rd);
        bus(1'b1, 8'h3C, 32'hFFFF_FFFF);
        bus(1'b0, 8'h3C, 32'h0);
        cmp("unmapped", 32'h0, rd);
        bus(1'b1, mdu_pkg::ADDR_HIGH, 32'h0000_1234);
        bus(1'b1, mdu_pkg::ADDR_LOW, 32'h0000_5678);
        bus(1'b0, mdu_pkg::ADDR_CTRL, 32'h0);
        cmp("in use", 32'h10, rd);
        bus(1'b0, mdu_pkg::ADDR_HIGH, 32'h0);
        cmp("high", 32'h1234, rd);
        bus(1'b0, mdu_pkg::ADDR_LOW, 32'h0);
        cmp("low", 32'h5678, rd);
        bus(1'b0, mdu_pkg::ADDR_CTRL, 32'h0);
        cmp("ctrl", 32'h0, rd);
    endtask
    // command codes 0 to 3, 6 and 7 with operands and results
    task automatic s_ops;
        logic [2:0] cm [7] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h3, 3'h6, 3'h7};
        logic [15:0] hi [7] = '{16'h0000, 16'h0000, 16'h1234, 16'hFFFF,
            16'h5555, 16'h0001, 16'h0002};
        logic [15:0] lo [7] = '{16'hFFFF, 16'hFFFE, 16'h0064, 16'hFFF9,
            16'hFF9C, 16'h0000, 16'h0000};
        logic [15:0] op [7] = '{16'hFFFF, 16'h0003, 16'h0007, 16'h0002,
            16'h0007, 16'h0003, 16'h0001};
        logic [31:0] ex [7] = '{32'hFFFE_0001, 32'hFFFF_FFFA, 32'h0002_000E,
            32'hFFFF_FFFD, 32'hFFFE_FFF2, 32'h0001_5555, 32'h0000_0000};
        logic [6:0] ov = 7'h41;
        logic [31:0] res;
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, mdu_pkg::ADDR_CTRL, 32'h0);
            bus(1'b1, mdu_pkg::ADDR_HIGH, {16'h0, hi[i]});
            bus(1'b1, mdu_pkg::ADDR_LOW, {16'h0, lo[i]});
            bus(1'b1, mdu_pkg::ADDR_OPND, {16'h0, op[i]});
            bus(1'b1, mdu_pkg::ADDR_CMD, {16'h0100, 13'h0, cm[i]});
            bus(1'b0, mdu_pkg::ADDR_STAT, 32'h0);
            cmp("started", 32'h4, rd & 32'h4);
            wait_idle();
            cmp("overflow", {31'h0, ov[i]}, rd & 32'h1);
            bus(1'b0, mdu_pkg::ADDR_HIGH, 32'h0);
            res[31:16] = rd[15:0];
            bus(1'b0, mdu_pkg::ADDR_LOW, 32'h0);
            res[15:0] = rd[15:0];
            if (i < 6) cmp("result", ex[i], res);
            bus(1'b0, mdu_pkg::ADDR_CTRL, 32'h0);
            cmp("released", 32'h0, rd & 32'h10);
        end
    endtask
    // sticky status, mask and clear
    task automatic s_irq;
        bus(1'b0, mdu_pkg::ADDR_IRQST, 32'h0);
        cmp("irq status", 32'h3, rd);
        cmp("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, mdu_pkg::ADDR_IRQMSK, 32'h2);
        @(posedge clk);
        cmp("irq raised", 32'h1, {31'h0, irq});
        bus(1'b1, mdu_pkg::ADDR_IRQST, 32'h2);
        @(posedge clk);
        cmp("irq cleared", 32'h0, {31'h0, irq});
        bus(1'b0, mdu_pkg::ADDR_IRQST, 32'h0);
        cmp("irq left", 32'h1, rd);
    endtask
    // interrupt in mid-operation, restore and return
    task automatic s_resume;
        bus(1'b1, mdu_pkg::ADDR_CTRL, 32'h0);
        bus(1'b1, mdu_pkg::ADDR_CMD, 32'hABCD_0000);
        bus(1'b0, mdu_pkg::ADDR_CTRL, 32'h0);
        cmp("in use at start", 32'h10, rd & 32'h10);
        take_req <= 1'b1;
        @(posedge clk);
        take_req <= 1'b0;
        repeat (4) @(posedge clk);
        cmp("pushed", 32'hABCD, {16'h0, pushed_addr});
        bus(1'b0, mdu_pkg::ADDR_STAT, 32'h0);
        cmp("interrupted", 32'h2, rd & 32'h6);
        bus(1'b0, mdu_pkg::ADDR_CTRL, 32'h0);
        cmp("restart kept", 32'h1, {31'h0, |rd[3:0]});
        bus(1'b1, mdu_pkg::ADDR_CTRL, 32'h0000_0010);
        bus(1'b0, mdu_pkg::ADDR_CTRL, 32'h0);
        cmp("ctrl cleared", 32'h10, rd);
        bus(1'b1, mdu_pkg::ADDR_RETURN_FROM_INTERRUPT, 32'h2);
        repeat (3) @(posedge clk);
        cmp("refetch", 32'h1, n_refetch);
        wait_idle();
        take_req <= 1'b1;
        @(posedge clk);
        take_req <= 1'b0;
        repeat (4) @(posedge clk);
        cmp("pushed idle", 32'h1111, {16'h0, pushed_addr});
        bus(1'b1, mdu_pkg::ADDR_RETURN_FROM_INTERRUPT, 32'h0);
        repeat (3) @(posedge clk);
        cmp("no refetch", 32'h1, n_refetch);
    endtask
    // reset, then the scenarios
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        s_regs();
        s_ops();
        s_irq();
        s_resume();
        complete_run();
    end
endmodule
`default_nettype wire

/* File: verilog/mdu_pkg.sv */
// mdu_pkg: constants for the multiply/divide unit.
// assumes a 32-bit ahb-lite register bus and a 50 MHz core clock.
package mdu_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_LOW = 8'h00;
    localparam logic [7:0] ADDR_HIGH = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_CMD = 8'h0C;
    localparam logic [7:0] ADDR_OPND = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQST = 8'h18;
    localparam logic [7:0] ADDR_IRQMSK = 8'h1C;
    localparam logic [7:0] ADDR_RETURN_FROM_INTERRUPT = 8'h20;
    // control register fields
    localparam int CTRL_RIU_BIT = 4;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_RIU_MASK = 16'h0010;
    localparam logic [15:0] CTRL_WR_MASK = 16'h001F;
    // status word bits
    localparam int ST_OVF_BIT = 0;
    localparam int ST_IOP_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    // interrupt status bits
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_OVF_BIT = 1;
    localparam int IRQ_WIDTH = 2;
    // command codes in the command register
    localparam logic [1:0] CMD_UNSIGNED_MULTIPLY_OP = 2'h0;
    localparam logic [1:0] CMD_MULS = 2'h1;
    localparam logic [1:0] CMD_DIVU = 2'h2;
    localparam logic [1:0] CMD_DIVS = 2'h3;
    localparam int CMD_SIGNED_BIT = 0;
    localparam int CMD_DIV_BIT = 1;
    localparam int CMD_LONG_BIT = 2;
    // ahb codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // operation step count
    localparam int STEPS = 16;
    typedef enum logic [1:0] {
        MDU_IDLE, MDU_RUN, MDU_FIX
    } mdu_state_type;
endpackage

/* File: verilog/mdu_unit.sv */
// mdu_unit: 16-bit multiply/divide unit with ahb-lite register access.
// assumes one clock, synchronous active-high reset, single word transfers.
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module mdu_unit #(
    parameter int ADDR_WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [ADDR_WIDTH-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // core interrupt side
    input wire logic irq_take,
    input wire logic [15:0] irq_pc,
    output logic [15:0] return_addr,
    output logic refetch,
    // interrupt output
    output logic irq
);
    if (ADDR_WIDTH < 6) begin
        $error("mdu_unit: ADDR_WIDTH too small");
    end

    logic [15:0] result_low_half;
    logic [15:0] result_high_half;
    logic [15:0] ctrl;
    logic [15:0] opnd;
    logic [15:0] op_pc;
    logic [2:0] op_cmd;
    localparam int IRQ_WIDTH_L = mdu_pkg::IRQ_WIDTH;
    logic ovf_flag;
    logic interrupted_op_flag;
    logic [IRQ_WIDTH_L-1:0] irq_stat;
    logic [IRQ_WIDTH_L-1:0] irq_mask;
    logic [4:0] step;
    logic [31:0] acc;
    logic [15:0] dvs;
    logic neg_q, neg_r, pre_ovf;
    mdu_pkg::mdu_state_type state;

    // address phase capture
    logic wr_pend;
    logic [ADDR_WIDTH-1:0] wr_addr;
    logic rd_now, wr_now;
    logic [7:0] a8, w8;
    assign a8 = 8'(haddr);
    assign w8 = 8'(wr_addr);
    assign rd_now = hsel && hready && htrans == mdu_pkg::HTRANS_NONSEQ
        && !hwrite;
    assign wr_now = wr_pend;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end else begin
            wr_pend <= hsel && hready && hwrite
                && htrans == mdu_pkg::HTRANS_NONSEQ;
            wr_addr <= haddr;
        end
    end

    // start strobe and completion strobe
    logic start, done, return_from_interrupt;
    assign start = wr_now && w8 == mdu_pkg::ADDR_CMD;
    assign return_from_interrupt = wr_now && w8 == mdu_pkg::ADDR_RETURN_FROM_INTERRUPT;
    assign done = state == mdu_pkg::MDU_FIX;

    // absolute values for signed forms
    logic sgn, is_div, long_div, top_sign;
    logic [31:0] dividend_abs;
    logic [15:0] opnd_abs;
    logic [15:0] low_abs;
    assign sgn = hwdata[mdu_pkg::CMD_SIGNED_BIT];
    assign is_div = hwdata[mdu_pkg::CMD_DIV_BIT];
    assign long_div = is_div && hwdata[mdu_pkg::CMD_LONG_BIT];
    assign top_sign = long_div ? result_high_half[15] : result_low_half[15];
    assign opnd_abs = (sgn && opnd[15]) ? 16'(-opnd) : opnd;
    assign low_abs = (sgn && result_low_half[15])
        ? 16'(-result_low_half) : result_low_half;
    assign dividend_abs = (sgn && result_high_half[15])
        ? 32'(-{result_high_half, result_low_half})
        : {result_high_half, result_low_half};

    // one shift-add or shift-subtract step
    logic [16:0] trial;
    assign trial = {acc[31:16], acc[15]} - {1'b0, dvs};

    // operation sequencer
    // multi-cycle datapath
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= mdu_pkg::MDU_IDLE;
            step <= '0;
            acc <= '0;
            dvs <= '0;
            op_cmd <= '0;
            neg_q <= 1'b0;
            neg_r <= 1'b0;
            pre_ovf <= 1'b0;
            op_pc <= '0;
        end else begin
            case (state)
                mdu_pkg::MDU_IDLE: begin
                    if (start) begin
                        op_cmd <= hwdata[2:0];
                        op_pc <= hwdata[31:16];
                        step <= 5'(ctrl[3:0]);
                        dvs <= opnd_abs;
                        state <= mdu_pkg::MDU_RUN;
                        neg_q <= sgn && (opnd[15] ^ top_sign);
                        neg_r <= sgn && is_div && top_sign;
                        acc <= long_div ? dividend_abs
                            : {16'h0000, low_abs};
                        pre_ovf <= long_div
                            && dividend_abs[31:16] >= opnd_abs;
                    end
                end
                mdu_pkg::MDU_RUN: begin
                    if (irq_take) begin
                        state <= mdu_pkg::MDU_IDLE;
                    end else begin
                        if (op_cmd[mdu_pkg::CMD_DIV_BIT]) begin
                            // restoring division step
                            if (!trial[16]) begin
                                acc <= {trial[15:0], acc[14:0], 1'b1};
                            end else begin
                                acc <= {acc[30:0], 1'b0};
                            end
                        end else begin
                            // shift-add multiply step
                            acc <= acc[0]
                                ? {(17'(acc[31:16]) + 17'(dvs)),
                                   acc[15:1]}
                                : {1'b0, acc[31:1]};
                        end
                        step <= step + 5'd1;
                        if (step == 5'(mdu_pkg::STEPS - 1)) begin
                            state <= mdu_pkg::MDU_FIX;
                        end
                    end
                end
                mdu_pkg::MDU_FIX: begin
                    state <= mdu_pkg::MDU_IDLE;
                end
                default: state <= mdu_pkg::MDU_IDLE;
            endcase
        end
    end

    // signed fix-up of the finished result
    logic [31:0] prod;
    logic [15:0] quot, rem;
    logic ovf_calc;
    assign prod = neg_q ? 32'(-acc) : acc;
    assign quot = neg_q ? 16'(-acc[15:0]) : acc[15:0];
    assign rem = neg_r ? 16'(-acc[31:16]) : acc[31:16];
    always_comb begin
        if (op_cmd[mdu_pkg::CMD_DIV_BIT]) begin
            ovf_calc = dvs == 16'h0000 || pre_ovf
                || (op_cmd[mdu_pkg::CMD_SIGNED_BIT] && quot[15] != neg_q
                && quot != 16'h0000);
        end else begin
            ovf_calc = prod[31:16] != (op_cmd[mdu_pkg::CMD_SIGNED_BIT]
                ? {16{prod[15]}} : 16'h0000);
        end
    end

    // result pair registers
    // 32-bit pair
    always_ff @(posedge clk) begin
        if (srst) begin
            result_low_half <= '0;
            result_high_half <= '0;
        end else if (done) begin
            if (op_cmd[mdu_pkg::CMD_DIV_BIT]) begin
                result_low_half <= quot;
                result_high_half <= rem;
            end else begin
                result_low_half <= prod[15:0];
                result_high_half <= prod[31:16];
            end
        end else if (wr_now && state == mdu_pkg::MDU_IDLE) begin
            if (w8 == mdu_pkg::ADDR_LOW) begin
                result_low_half <= hwdata[15:0];
            end
            if (w8 == mdu_pkg::ADDR_HIGH) begin
                result_high_half <= hwdata[15:0];
            end
        end
    end

    // operand register
    always_ff @(posedge clk) begin
        if (srst) begin
            opnd <= '0;
        end else if (wr_now && w8 == mdu_pkg::ADDR_OPND) begin
            opnd <= hwdata[15:0];
        end
    end

    // control register: in-use flag and restart step count
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl <= mdu_pkg::CTRL_RESET;
        end else begin
            if (wr_now && w8 == mdu_pkg::ADDR_CTRL) begin
                ctrl <= hwdata[15:0] & mdu_pkg::CTRL_WR_MASK;
            end else if (state == mdu_pkg::MDU_RUN && irq_take) begin
                ctrl[3:0] <= step[3:0];
            end else if (done) begin
                ctrl[3:0] <= 4'h0;
            end
            if (rd_now && a8 == mdu_pkg::ADDR_LOW) begin
                ctrl[mdu_pkg::CTRL_RIU_BIT] <= 1'b0;
            end
            // set on half write or start
            if (start || (wr_now && (w8 == mdu_pkg::ADDR_LOW
                || w8 == mdu_pkg::ADDR_HIGH))) begin
                ctrl[mdu_pkg::CTRL_RIU_BIT] <= 1'b1;
            end
        end
    end

    // status flags: overflow and interrupted op
    always_ff @(posedge clk) begin
        if (srst) begin
            ovf_flag <= 1'b0;
            interrupted_op_flag <= 1'b0;
            return_addr <= '0;
            refetch <= 1'b0;
        end else begin
            refetch <= 1'b0;
            if (done) begin
                ovf_flag <= ovf_calc;
            end
            if (wr_now && w8 == mdu_pkg::ADDR_STAT) begin
                interrupted_op_flag <= hwdata[mdu_pkg::ST_IOP_BIT];
                ovf_flag <= hwdata[mdu_pkg::ST_OVF_BIT];
            end
            if (irq_take && state == mdu_pkg::MDU_RUN) begin
                return_addr <= op_pc;
                interrupted_op_flag <= 1'b1;
            end else if (irq_take) begin
                return_addr <= irq_pc;
                interrupted_op_flag <= 1'b0;
            end
            if (return_from_interrupt) begin
                refetch <= interrupted_op_flag;
                interrupted_op_flag <= hwdata[mdu_pkg::ST_IOP_BIT];
            end
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_stat <= '0;
            irq_mask <= '0;
        end else begin
            if (wr_now && w8 == mdu_pkg::ADDR_IRQMSK) begin
                irq_mask <= hwdata[IRQ_WIDTH_L-1:0];
            end
            irq_stat[mdu_pkg::IRQ_DONE_BIT] <= done
                || (irq_stat[mdu_pkg::IRQ_DONE_BIT] && !(wr_now
                && w8 == mdu_pkg::ADDR_IRQST
                && hwdata[mdu_pkg::IRQ_DONE_BIT]));
            irq_stat[mdu_pkg::IRQ_OVF_BIT] <= (done && ovf_calc)
                || (irq_stat[mdu_pkg::IRQ_OVF_BIT] && !(wr_now
                && w8 == mdu_pkg::ADDR_IRQST
                && hwdata[mdu_pkg::IRQ_OVF_BIT]));
        end
    end
    assign irq = |(irq_stat & irq_mask);

    // read data register
    always_ff @(posedge clk) begin
        if (srst) begin
            hrdata <= '0;
        end else if (rd_now) begin
            case (a8)
                mdu_pkg::ADDR_LOW: hrdata <= {16'h0000, result_low_half};
                mdu_pkg::ADDR_HIGH: hrdata <= {16'h0000, result_high_half};
                mdu_pkg::ADDR_CTRL: hrdata <= {16'h0000, ctrl};
                mdu_pkg::ADDR_OPND: hrdata <= {16'h0000, opnd};
                mdu_pkg::ADDR_STAT: hrdata <= {29'h0000_0000,
                    state != mdu_pkg::MDU_IDLE, interrupted_op_flag,
                    ovf_flag};
                mdu_pkg::ADDR_IRQST: hrdata <= 32'(irq_stat);
                mdu_pkg::ADDR_IRQMSK: hrdata <= 32'(irq_mask);
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire
